//--- actb_pkg.sv
package actb_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam int TADJ_W = 8;
   localparam int OADJ_W = 12;
   localparam int NUM_T  = 6;
   localparam int NUM_O  = 3;
   localparam logic [ADDR_W-1:0] OFF_CORE_A_DUAL_TT   = 12'h310;
   localparam logic [ADDR_W-1:0] OFF_CORE_B_DUAL_TT   = 12'h313;
   localparam logic [ADDR_W-1:0] OFF_CORE_A_S1_TT     = 12'h314;
   localparam logic [ADDR_W-1:0] OFF_CORE_B_S1_TT     = 12'h315;
   localparam logic [ADDR_W-1:0] OFF_CORE_A_S2_TT     = 12'h31A;
   localparam logic [ADDR_W-1:0] OFF_CORE_B_S2_TT     = 12'h31B;
   localparam logic [ADDR_W-1:0] OFF_CORE_A_D1_OT     = 12'h344;
   localparam logic [ADDR_W-1:0] OFF_CORE_A_D2_OT     = 12'h346;
   localparam logic [ADDR_W-1:0] OFF_CORE_A_S1_OT     = 12'h348;
   // Index of each timing and offset trim in the bank.
   localparam int TI_A_DUAL = 0;
   localparam int TI_B_DUAL = 1;
   localparam int TI_A_S1   = 2;
   localparam int TI_B_S1   = 3;
   localparam int TI_A_S2   = 4;
   localparam int TI_B_S2   = 5;
   localparam int OI_A_D1   = 0;
   localparam int OI_A_D2   = 1;
   localparam int OI_A_S1   = 2;
   localparam logic [DATA_W-1:0] RD_ZERO = 16'h0000;
   localparam logic [TADJ_W-1:0] TADJ_ZERO = 8'h00;
   localparam logic [OADJ_W-1:0] OADJ_ZERO = 12'h000;

   // Register port request.
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } actb_req_t;

   // Operating context of the converter.
   typedef struct packed {
      logic single_mode;
      logic second_input;
      logic fg_cal_en;
   } actb_mode_t;

   // Trim values applied to the cores.
   typedef struct packed {
      logic              a_t_valid;
      logic [TADJ_W-1:0] a_timing;
      logic              b_t_valid;
      logic [TADJ_W-1:0] b_timing;
      logic              a_o_valid;
      logic [OADJ_W-1:0] a_offset;
   } actb_trim_t;

   typedef enum logic [1:0] {
      ST_LOAD = 2'b00,
      ST_RUN  = 2'b01
   } actb_state_t;
endpackage

//--- actb_trim_bank.sv
`timescale 1ns/10ps
`default_nettype none
module actb_trim_bank (
   input  wire logic                                      core_clk,
   input  wire logic                                      srst,
   input  wire actb_pkg::actb_req_t                       req,
   output logic        [actb_pkg::DATA_W-1:0]             rdata,
   input  wire logic   [actb_pkg::NUM_T*actb_pkg::TADJ_W-1:0] fuse_timing,
   input  wire logic   [actb_pkg::NUM_O*actb_pkg::DATA_W-1:0] fuse_offset,
   input  wire actb_pkg::actb_mode_t                      mode,
   output actb_pkg::actb_trim_t                           trim,
   output logic                                           fuse_loaded
);
   import actb_pkg::*;

   // *************************************************************
   // Address decode
   // *************************************************************

   // Timing trim index for an address, or NUM_T when unmapped.
   function automatic int t_index(input logic [ADDR_W-1:0] a);
      case (a)
         OFF_CORE_A_DUAL_TT: t_index = TI_A_DUAL;
         OFF_CORE_B_DUAL_TT: t_index = TI_B_DUAL;
         OFF_CORE_A_S1_TT:   t_index = TI_A_S1;
         OFF_CORE_B_S1_TT:   t_index = TI_B_S1;
         OFF_CORE_A_S2_TT:   t_index = TI_A_S2;
         OFF_CORE_B_S2_TT:   t_index = TI_B_S2;
         default:            t_index = NUM_T;
      endcase
   endfunction

   // Offset trim index for an address, or NUM_O when unmapped.
   function automatic int o_index(input logic [ADDR_W-1:0] a);
      case (a)
         OFF_CORE_A_D1_OT: o_index = OI_A_D1;
         OFF_CORE_A_D2_OT: o_index = OI_A_D2;
         OFF_CORE_A_S1_OT: o_index = OI_A_S1;
         default:          o_index = NUM_O;
      endcase
   endfunction

   // *************************************************************
   // Trim storage
   // *************************************************************

   actb_state_t       state_reg, state_next;
   logic [TADJ_W-1:0] tt_reg [NUM_T];
   logic [TADJ_W-1:0] tt_next [NUM_T];
   logic [DATA_W-1:0] ot_reg [NUM_O];
   logic [DATA_W-1:0] ot_next [NUM_O];
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   int                ti, oi;

   // Fuse load after reset, then software writes and reads.
   always_comb begin
      state_next = state_reg;
      tt_next    = tt_reg;
      ot_next    = ot_reg;
      rdata_next = RD_ZERO;
      ti         = t_index(req.addr);
      oi         = o_index(req.addr);
      case (state_reg)
         ST_LOAD: begin
            for (int i = 0; i < NUM_T; i++) begin
               tt_next[i] = fuse_timing[i*TADJ_W +: TADJ_W];
            end
            for (int i = 0; i < NUM_O; i++) begin
               ot_next[i] = fuse_offset[i*DATA_W +: DATA_W];
            end
            state_next = ST_RUN;
         end
         ST_RUN: begin
            if (req.wr && ti < NUM_T) begin
               tt_next[ti] = req.wdata[TADJ_W-1:0];
            end
            if (req.wr && oi < NUM_O) begin
               ot_next[oi] = req.wdata;
            end
            if (req.rd && ti < NUM_T) begin
               rdata_next = {{(DATA_W-TADJ_W){1'b0}}, tt_reg[ti]};
            end else if (req.rd && oi < NUM_O) begin
               rdata_next = ot_reg[oi];
            end
         end
         default: state_next = ST_LOAD;
      endcase
   end

   // Registers the bank; reset restarts the fuse load.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= ST_LOAD;
         rdata_reg <= RD_ZERO;
         for (int i = 0; i < NUM_T; i++) begin
            tt_reg[i] <= TADJ_ZERO;
         end
         for (int i = 0; i < NUM_O; i++) begin
            ot_reg[i] <= RD_ZERO;
         end
      end else begin
         state_reg <= state_next;
         rdata_reg <= rdata_next;
         tt_reg    <= tt_next;
         ot_reg    <= ot_next;
      end
   end

   assign rdata       = rdata_reg;
   assign fuse_loaded = (state_reg == ST_RUN);

   // *************************************************************
   // Trim selection
   // *************************************************************

   actb_trim_t trim_reg, trim_next;

   // Picks the timing trim per core and, except for the single mode second input, the core A offset trim that match the context.
   always_comb begin
      trim_next = '0;
      if (mode.fg_cal_en && fuse_loaded) begin
         if (!mode.single_mode) begin
            trim_next.a_t_valid = 1'b1;
            trim_next.a_timing  = tt_reg[TI_A_DUAL];
            trim_next.b_t_valid = 1'b1;
            trim_next.b_timing  = tt_reg[TI_B_DUAL];
            trim_next.a_o_valid = 1'b1;
            trim_next.a_offset  = mode.second_input ?
                                  ot_reg[OI_A_D2][OADJ_W-1:0] :
                                  ot_reg[OI_A_D1][OADJ_W-1:0];
         end else if (!mode.second_input) begin
            trim_next.a_t_valid = 1'b1;
            trim_next.a_timing  = tt_reg[TI_A_S1];
            trim_next.b_t_valid = 1'b1;
            trim_next.b_timing  = tt_reg[TI_B_S1];
            trim_next.a_o_valid = 1'b1;
            trim_next.a_offset  = ot_reg[OI_A_S1][OADJ_W-1:0];
         end else begin
            trim_next.a_t_valid = 1'b1;
            trim_next.a_timing  = tt_reg[TI_A_S2];
            trim_next.b_t_valid = 1'b1;
            trim_next.b_timing  = tt_reg[TI_B_S2];
         end
      end
   end

   // Registers the applied trims; unmatched ones are ignored.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         trim_reg <= '0;
      end else begin
         trim_reg <= trim_next;
      end
   end

   assign trim = trim_reg;

   // *************************************************************
   // Assertions
   // *************************************************************

   sequence s_write_a_dual;
      fuse_loaded && req.wr && req.addr == OFF_CORE_A_DUAL_TT;
   endsequence

   property p_fuse_load;
      @(posedge core_clk) disable iff (srst)
         $past(srst) |-> ##1 tt_reg[TI_B_S2] == $past(fuse_timing[TI_B_S2*TADJ_W +: TADJ_W]);
   endproperty
   a_fuse_load: assert property (p_fuse_load) else $error("Fuse value not loaded.");

   property p_readback;
      @(posedge core_clk) disable iff (srst)
         s_write_a_dual ##1 (req.rd && req.addr == OFF_CORE_A_DUAL_TT && !req.wr)
         |=> rdata == {{(DATA_W-TADJ_W){1'b0}}, $past(req.wdata[TADJ_W-1:0], 2)};
   endproperty
   a_readback: assert property (p_readback) else $error("Timing trim readback wrong.");

   property p_dual_a;
      @(posedge core_clk) disable iff (srst)
         (fuse_loaded && mode.fg_cal_en && !mode.single_mode)
         |=> trim.a_timing == $past(tt_reg[TI_A_DUAL]) && trim.b_timing == $past(tt_reg[TI_B_DUAL]);
   endproperty
   a_dual_a: assert property (p_dual_a) else $error("Dual timing trim wrong.");

   property p_single_first;
      @(posedge core_clk) disable iff (srst)
         (fuse_loaded && mode.fg_cal_en && mode.single_mode && !mode.second_input)
         |=> trim.b_timing == $past(tt_reg[TI_B_S1]) && trim.a_offset == $past(ot_reg[OI_A_S1][OADJ_W-1:0]);
   endproperty
   a_single_first: assert property (p_single_first) else $error("Single first trim wrong.");

   property p_single_second;
      @(posedge core_clk) disable iff (srst)
         (fuse_loaded && mode.fg_cal_en && mode.single_mode && mode.second_input)
         |=> trim.a_timing == $past(tt_reg[TI_A_S2]) && !trim.a_o_valid;
   endproperty
   a_single_second: assert property (p_single_second) else $error("Single second trim wrong.");

   property p_dual_offset;
      @(posedge core_clk) disable iff (srst)
         (fuse_loaded && mode.fg_cal_en && !mode.single_mode && mode.second_input)
         |=> trim.a_offset == $past(ot_reg[OI_A_D2][OADJ_W-1:0]);
   endproperty
   a_dual_offset: assert property (p_dual_offset) else $error("Dual offset trim wrong.");

   property p_no_cal;
      @(posedge core_clk) disable iff (srst)
         !mode.fg_cal_en |=> !trim.a_t_valid && !trim.b_t_valid && !trim.a_o_valid;
   endproperty
   a_no_cal: assert property (p_no_cal) else $error("Trim applied without calibration.");

   property p_unmapped_read;
      @(posedge core_clk) disable iff (srst)
         (req.rd && t_index(req.addr) == NUM_T && o_index(req.addr) == NUM_O) |=> rdata == RD_ZERO;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero.");

   // Operating contexts in which a trim set is selected.
   sequence s_dual_cal;
      fuse_loaded && mode.fg_cal_en && !mode.single_mode;
   endsequence

   sequence s_single_first_cal;
      fuse_loaded && mode.fg_cal_en && mode.single_mode && !mode.second_input;
   endsequence

   sequence s_single_second_cal;
      fuse_loaded && mode.fg_cal_en && mode.single_mode && mode.second_input;
   endsequence

   // A write to the first offset trim that is read back at once.
   sequence s_write_offset;
      fuse_loaded && req.wr && req.addr == OFF_CORE_A_D1_OT;
   endsequence

   // Core B takes its dual mode timing trim.
   property p_dual_b;
      @(posedge core_clk) disable iff (srst)
         s_dual_cal |=> trim.b_t_valid && trim.b_timing == $past(tt_reg[TI_B_DUAL]);
   endproperty
   a_dual_b: assert property (p_dual_b) else $error("Core B dual timing trim wrong.");

   // Core A takes its single mode first input timing trim.
   property p_single_first_a;
      @(posedge core_clk) disable iff (srst)
         s_single_first_cal |=> trim.a_t_valid && trim.a_timing == $past(tt_reg[TI_A_S1]);
   endproperty
   a_single_first_a: assert property (p_single_first_a) else $error("Core A first trim wrong.");

   // Core B takes its single mode second input timing trim.
   property p_single_second_b;
      @(posedge core_clk) disable iff (srst)
         s_single_second_cal |=> trim.b_t_valid && trim.b_timing == $past(tt_reg[TI_B_S2]);
   endproperty
   a_single_second_b: assert property (p_single_second_b) else $error("Core B second trim wrong.");

   // Core A takes the dual mode first input offset when that input is sampled.
   property p_dual_first_offset;
      @(posedge core_clk) disable iff (srst)
         (s_dual_cal ##0 !mode.second_input) |=> trim.a_o_valid && trim.a_offset == $past(ot_reg[OI_A_D1][OADJ_W-1:0]);
   endproperty
   a_dual_first_offset: assert property (p_dual_first_offset) else $error("Dual first offset wrong.");

   // The single mode first input offset is flagged as applied.
   property p_single_offset_valid;
      @(posedge core_clk) disable iff (srst)
         s_single_first_cal |=> trim.a_o_valid;
   endproperty
   a_single_offset_valid: assert property (p_single_offset_valid) else $error("Single offset not applied.");

   // The reserved offset bits are kept and read back as written.
   property p_offset_reserved;
      @(posedge core_clk) disable iff (srst)
         s_write_offset ##1 (req.rd && !req.wr && req.addr == OFF_CORE_A_D1_OT)
         |=> rdata[DATA_W-1:OADJ_W] == $past(req.wdata[DATA_W-1:OADJ_W], 2);
   endproperty
   a_offset_reserved: assert property (p_offset_reserved) else $error("Reserved offset bits lost.");

   // A timing trim reads back with its upper byte clear.
   property p_timing_width;
      @(posedge core_clk) disable iff (srst)
         (fuse_loaded && req.rd && t_index(req.addr) < NUM_T) |=> rdata[DATA_W-1:TADJ_W] == '0;
   endproperty
   a_timing_width: assert property (p_timing_width) else $error("Timing trim upper byte set.");

   // Reset clears the applied trims, the read data and the load flag.
   property p_reset_clear;
      @(posedge core_clk)
         srst |=> trim == '0 && !fuse_loaded && rdata == RD_ZERO;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("Reset did not clear outputs.");

   // A write during the fuse load loses to the factory value.
   property p_load_write;
      @(posedge core_clk) disable iff (srst)
         (!fuse_loaded && req.wr && req.addr == OFF_CORE_A_DUAL_TT)
         |=> tt_reg[TI_A_DUAL] == $past(fuse_timing[TI_A_DUAL*TADJ_W +: TADJ_W]);
   endproperty
   a_load_write: assert property (p_load_write) else $error("Write overrode fuse load.");

   // Read data stand only in the cycle after a read strobe.
   property p_rdata_idle;
      @(posedge core_clk) disable iff (srst)
         !req.rd |=> rdata == RD_ZERO;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("Read data held too long.");

   // No trim is applied before the fuse values are in place.
   property p_unloaded;
      @(posedge core_clk) disable iff (srst)
         !fuse_loaded |=> trim == '0;
   endproperty
   a_unloaded: assert property (p_unloaded) else $error("Trim applied before fuse load.");
endmodule
`default_nettype wire

//--- adc_core_trim_register_bank_test.sv
`timescale 1ns/10ps
`default_nettype none
module adc_core_trim_register_bank_test;
   import actb_pkg::*;
   // ***********************************************
   // Signals and storage
   // ***********************************************
   logic                           core_clk = 1'b0;
   logic                           srst     = 1'b1;
   actb_req_t                      req;
   logic        [DATA_W-1:0]       rdata;
   logic        [NUM_T*TADJ_W-1:0] fuse_timing;
   logic        [NUM_O*DATA_W-1:0] fuse_offset;
   actb_mode_t                     mode;
   actb_trim_t                     trim;
   logic                           fuse_loaded;
   int                             err_count = 0;
   int                             compares  = 0;
   int                             cycles    = 0;
   logic        [ADDR_W-1:0]       addr_tab [9];
   logic        [DATA_W-1:0]       shadow   [9];

   actb_trim_bank dut (
      .core_clk    (core_clk),
      .srst        (srst),
      .req         (req),
      .rdata       (rdata),
      .fuse_timing (fuse_timing),
      .fuse_offset (fuse_offset),
      .mode        (mode),
      .trim        (trim),
      .fuse_loaded (fuse_loaded)
   );

   // Clock of 8 ns period.
   always #4 core_clk = ~core_clk;

   // Cuts a hung run short after far more cycles than the tests need.
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         test_done();
      end
   end

   // ***********************************************
   // Shared tasks
   // ***********************************************
   // Counts a comparison and reports a mismatch.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One write cycle; the strobe is left for the next task to replace.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk);
   endtask

   // One read cycle; the data are judged in the cycle after the strobe.
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge core_clk);
      req <= '0;
      #1 chk(rdata, e);
      @(posedge core_clk);
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic test_done();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ***********************************************
   // Scenarios
   // ***********************************************
   // Reset clears outputs; a write during the fuse load is ignored.
   task automatic t_reset();
      repeat (4) @(posedge core_clk);
      #1 chk({15'h0000, fuse_loaded}, 16'h0000);
      chk(trim[15:0], 16'h0000);
      @(posedge core_clk);
      srst <= 1'b0;
      req  <= '{wr: 1'b1, rd: 1'b0, addr: OFF_CORE_A_DUAL_TT, wdata: 16'h00EE};
      @(posedge core_clk);
      req <= '0;
      @(posedge core_clk);
      #1 chk({15'h0000, fuse_loaded}, 16'h0001);
      @(posedge core_clk);
      $display("test reset done");
   endtask

   // Every register reads back its factory value; a hole reads zero.
   task automatic t_defaults();
      for (int i = 0; i < 9; i++) begin
         rd(addr_tab[i], shadow[i]);
      end
      rd(12'h311, 16'h0000);
      $display("test defaults done");
   endtask

   // Writes replace values; timing keeps 8 bits, offset keeps 16.
   task automatic t_write();
      logic [DATA_W-1:0] d;
      for (int i = 0; i < 9; i++) begin
         d = 16'hF0A5 + 16'(i) * 16'h1111;
         shadow[i] = (i < NUM_T) ? {8'h00, d[7:0]} : d;
         wr(addr_tab[i], d);
         rd(addr_tab[i], shadow[i]);
      end
      wr(12'h312, 16'h1234);
      rd(12'h312, 16'h0000);
      rd(OFF_CORE_A_DUAL_TT, shadow[0]);
      $display("test write done");
   endtask

   // Applies one operating context and checks the selected trims.
   task automatic mode_chk(input logic s, input logic sec, input logic fg);
      logic [7:0]  ea;
      logic [7:0]  eb;
      logic [11:0] eo;
      logic        ev;
      logic        eov;
      mode <= '{single_mode: s, second_input: sec, fg_cal_en: fg};
      repeat (2) @(posedge core_clk);
      ev  = fg;
      eov = fg && !(s && sec);
      ea  = !fg ? 8'h00 : !s ? shadow[0][7:0] : sec ? shadow[4][7:0] : shadow[2][7:0];
      eb  = !fg ? 8'h00 : !s ? shadow[1][7:0] : sec ? shadow[5][7:0] : shadow[3][7:0];
      eo  = !eov ? 12'h000 : s ? shadow[8][11:0] : sec ? shadow[7][11:0] : shadow[6][11:0];
      #1 chk({7'h00, trim.a_t_valid, trim.a_timing}, {7'h00, ev, ea});
      chk({7'h00, trim.b_t_valid, trim.b_timing}, {7'h00, ev, eb});
      chk({3'h0, trim.a_o_valid, eov ? trim.a_offset : 12'h000}, {3'h0, eov, eo});
      @(posedge core_clk);
   endtask

   // Walks every combination of mode, input and calibration.
   task automatic t_modes();
      for (int m = 0; m < 8; m++) begin
         mode_chk(m[2], m[1], m[0]);
      end
      $display("test modes done");
   endtask

   // ***********************************************
   // Main sequence
   // ***********************************************
   initial begin
      req         = '0;
      mode        = '0;
      fuse_timing = 48'h3C_2B_1A_69_58_47;
      fuse_offset = 48'hA348_5346_F344;
      addr_tab    = '{OFF_CORE_A_DUAL_TT, OFF_CORE_B_DUAL_TT, OFF_CORE_A_S1_TT,
                      OFF_CORE_B_S1_TT, OFF_CORE_A_S2_TT, OFF_CORE_B_S2_TT,
                      OFF_CORE_A_D1_OT, OFF_CORE_A_D2_OT, OFF_CORE_A_S1_OT};
      for (int i = 0; i < 9; i++) begin
         shadow[i] = (i < NUM_T) ? {8'h00, fuse_timing[i*8 +: 8]} : fuse_offset[(i-6)*16 +: 16];
      end
      t_reset();
      t_defaults();
      t_modes();
      t_write();
      t_modes();
      test_done();
   end
endmodule
`default_nettype wire
